// [hdl/hfseq_top.sv]
// Purpose: Hiccup fault sequencer: fault detection, cool-down, internal soft-start
// Assumes: Comparators asynchronous to mclk_i; PWM gate requests synchronous
// Notes:   Soft-start ramp is a digital code compared against other reference codes
//          Gate outputs lag the PWM requests by one cycle
`timescale 1ns/1ps
`default_nettype none
module hfseq_top (
    // Clock and reset (reset = supply_low_lockout or shutdown)
    input  wire logic                          mclk_i,
    input  wire logic                          arst_n_i,
    // Fault comparators from the power stage
    input  wire hfseq_pkg::hfseq_cmp_t         cmp_i,
    // Gate requests from the PWM core
    input  wire hfseq_pkg::hfseq_gate_t        gate_req_i,
    // Reference sources
    input  wire logic [hfseq_pkg::REF_W-1:0]   bandgap_ref_i,
    input  wire logic [hfseq_pkg::REF_W-1:0]   ext_ss_level_i,
    input  wire logic                          ext_ss_done_i,
    // Gate drives and status
    output logic      [1:0]                    gate_o,
    output logic      [hfseq_pkg::REF_W-1:0]   ea_ref_o,
    output logic                               hiccup_o,
    output logic                               soft_start_o,
    output logic                               hiccup_enter_o
);
    localparam logic [hfseq_pkg::TMR_W-1:0] COOL_END =
        hfseq_pkg::TMR_W'(hfseq_pkg::COOL_CYC - 1);
    localparam logic [hfseq_pkg::TMR_W-1:0] SS_END =
        hfseq_pkg::TMR_W'(hfseq_pkg::SS_CYC - 1);
    localparam logic [hfseq_pkg::SHORT_W-1:0] UV_END =
        hfseq_pkg::SHORT_W'(hfseq_pkg::UV_CYC - 1);
    localparam logic [hfseq_pkg::SHORT_W-1:0] HS_BLANK =
        hfseq_pkg::SHORT_W'(hfseq_pkg::HS_BLANK_CYC);
    localparam logic [hfseq_pkg::SHORT_W-1:0] LS_DELAY =
        hfseq_pkg::SHORT_W'(hfseq_pkg::LS_DELAY_CYC);
    // Ramp step: full scale over the soft-start interval, at least one code
    localparam int RAMP_DIV = hfseq_pkg::SS_CYC / (1 << hfseq_pkg::REF_W);
    localparam logic [hfseq_pkg::TMR_W-1:0] RAMP_PRE =
        hfseq_pkg::TMR_W'((RAMP_DIV < 1) ? 0 : RAMP_DIV - 1);

    function automatic logic [hfseq_pkg::REF_W-1:0] min2(
        input logic [hfseq_pkg::REF_W-1:0] a,
        input logic [hfseq_pkg::REF_W-1:0] b
    );
        min2 = (a < b) ? a : b;
    endfunction

    // Two-stage synchronisers for the three comparators. They switch with the
    // power stage, not with mclk_i, so only the second stage is ever read;
    // the price is two cycles of extra fault latency.
    hfseq_pkg::hfseq_cmp_t sync1_r;
    hfseq_pkg::hfseq_cmp_t sync2_r;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= cmp_i;
            sync2_r <= sync1_r;
        end
    end
    wire ls_ovc_s = sync2_r.ls_ovc;
    wire hs_ovc_s = sync2_r.hs_ovc;
    wire uv_s     = sync2_r.output_undervoltage_fault;

    hfseq_pkg::hfseq_state_t state_r;
    hfseq_pkg::hfseq_state_t state_nxt;
    logic [hfseq_pkg::TMR_W-1:0]   tmr_r;
    logic [hfseq_pkg::TMR_W-1:0]   pre_r;
    logic [hfseq_pkg::REF_W-1:0]   iss_r;
    logic [hfseq_pkg::SHORT_W-1:0] hs_blank_r;
    logic [hfseq_pkg::SHORT_W-1:0] ls_dly_r;
    logic [hfseq_pkg::SHORT_W-1:0] uv_cnt_r;
    logic [4:0]                    ls_cnt_r;
    logic [5:0]                    ls_clean_r;
    logic                          hs_req_d_r;
    logic                          ls_req_d_r;
    logic                          ls_armed_r;

    // Edges of the PWM gate requests
    wire hs_rise  = gate_req_i.hs_on & ~hs_req_d_r;
    wire ls_rise  = gate_req_i.ls_on & ~ls_req_d_r;
    // Off time starts when the high side turns off
    wire off_start = ~gate_req_i.hs_on & hs_req_d_r;

    wire running    = (state_r == hfseq_pkg::HFSEQ_RUN);
    wire in_ss      = (state_r == hfseq_pkg::HFSEQ_SOFT) | ~ext_ss_done_i;
    // Samples during cool-down are dropped: gates are off, and a stale level
    // must not preload the counter for the next run
    wire cooling    = (state_r == hfseq_pkg::HFSEQ_COOL);

    // High-side trip, masked while the blanking counter runs
    wire hs_blanked = (hs_blank_r != '0) | hs_rise;
    wire hs_trip    = hs_ovc_s & gate_req_i.hs_on & ~hs_blanked;

    // Low-side sample: once per off time, no earlier than the settle delay
    wire ls_sample  = ls_armed_r & (ls_dly_r == '0) & gate_req_i.ls_on & ~cooling;
    wire ls_event   = ls_sample & ls_ovc_s;
    wire ls_trip    = ls_event & (ls_cnt_r == hfseq_pkg::LS_TRIP_CNT - 5'h01);

    wire uv_trip    = ~in_ss & uv_s & (uv_cnt_r == UV_END);

    wire fault      = (state_r != hfseq_pkg::HFSEQ_COOL) & (hs_trip | ls_trip | uv_trip);

    wire cool_done  = (state_r == hfseq_pkg::HFSEQ_COOL) & (tmr_r == COOL_END);
    wire ss_done    = (state_r == hfseq_pkg::HFSEQ_SOFT) & (tmr_r == SS_END);
    wire ramp_step  = (state_r == hfseq_pkg::HFSEQ_SOFT) & (pre_r == RAMP_PRE)
                      & (iss_r != '1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            hfseq_pkg::HFSEQ_RUN:  begin
                if (fault) begin
                    state_nxt = hfseq_pkg::HFSEQ_COOL;
                end
            end
            hfseq_pkg::HFSEQ_COOL: begin
                if (cool_done) begin
                    state_nxt = hfseq_pkg::HFSEQ_SOFT;
                end
            end
            hfseq_pkg::HFSEQ_SOFT: begin
                if (fault) begin
                    state_nxt = hfseq_pkg::HFSEQ_COOL;
                end else if (ss_done) begin
                    state_nxt = hfseq_pkg::HFSEQ_RUN;
                end
            end
            default: state_nxt = hfseq_pkg::HFSEQ_COOL;
        endcase
    end

    // Any trip is a hiccup entry; cool-down ignores faults, so entry lasts one cycle
    wire enter   = fault;
    wire tmr_clr = enter | cool_done | ss_done;

    // One timer serves cool-down and soft-start; it idles in regulation so that
    // a long run can never wrap it into a false end of interval
    logic [hfseq_pkg::TMR_W-1:0] tmr_nxt;
    always_comb begin
        if (tmr_clr) begin
            tmr_nxt = '0;
        end else if (running) begin
            tmr_nxt = tmr_r;
        end else begin
            tmr_nxt = tmr_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= hfseq_pkg::HFSEQ_RUN;
            tmr_r   <= '0;
        end else begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
        end
    end

    // Internal soft-start level: cleared on entry, ramps during soft-start.
    // Full scale outside hiccup keeps it out of the minimum select, and the
    // ramp stops at full scale so it never wraps back to zero.
    logic [hfseq_pkg::REF_W-1:0] iss_nxt;
    logic [hfseq_pkg::TMR_W-1:0] pre_nxt;
    always_comb begin
        iss_nxt = iss_r;
        if (enter) begin
            iss_nxt = hfseq_pkg::REF_ZERO;
        end else if (ss_done) begin
            iss_nxt = '1;
        end else if (ramp_step) begin
            iss_nxt = iss_r + 1'b1;
        end
        pre_nxt = (tmr_clr | ramp_step) ? '0 : pre_r + 1'b1;
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            iss_r <= '1;
            pre_r <= '0;
        end else begin
            iss_r <= iss_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Request edge history; idle requests are low, so reset shows no false edge
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hs_req_d_r <= 1'b0;
            ls_req_d_r <= 1'b0;
        end else begin
            hs_req_d_r <= gate_req_i.hs_on;
            ls_req_d_r <= gate_req_i.ls_on;
        end
    end

    // High-side blanking: reloaded on every turn-on, so a short off time
    // cannot shorten the mask of the next pulse
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hs_blank_r <= '0;
        end else if (hs_rise) begin
            hs_blank_r <= HS_BLANK - 1'b1;
        end else if (hs_blank_r != '0) begin
            hs_blank_r <= hs_blank_r - 1'b1;
        end
    end

    // Low-side settle delay before the first comparison
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ls_dly_r <= '0;
        end else if (ls_rise) begin
            ls_dly_r <= LS_DELAY - 1'b1;
        end else if (ls_dly_r != '0) begin
            ls_dly_r <= ls_dly_r - 1'b1;
        end
    end

    // One sample per off time: armed at high-side turn-off, spent by the sample
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ls_armed_r <= 1'b0;
        end else if (ls_sample) begin
            ls_armed_r <= 1'b0;
        end else if (off_start) begin
            ls_armed_r <= 1'b1;
        end
    end

    // Low-side event counter with clean-cycle reset
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ls_cnt_r   <= '0;
            ls_clean_r <= '0;
        end else if (enter) begin
            ls_cnt_r   <= '0;
            ls_clean_r <= '0;
        end else if (ls_event) begin
            ls_cnt_r   <= ls_cnt_r + 5'h01;
            ls_clean_r <= '0;
        end else if (ls_sample) begin
            if (ls_clean_r == hfseq_pkg::LS_CLEAR_CNT - 6'h01) begin
                ls_cnt_r   <= '0;
                ls_clean_r <= '0;
            end else begin
                ls_clean_r <= ls_clean_r + 6'h01;
            end
        end
    end

    // Undervoltage glitch filter: must hold continuously.
    // Any gap restarts the count, so short dips never add up across pulses.
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            uv_cnt_r <= '0;
        end else if (!uv_s || in_ss || !running) begin
            uv_cnt_r <= '0;
        end else if (uv_cnt_r != UV_END) begin
            uv_cnt_r <= uv_cnt_r + 1'b1;
        end
    end

    // Outputs: gates registered, forced off outside regulation or soft-start.
    // The next state is used so the gates drop at the trip edge itself,
    // a cycle sooner than the registered state would allow.
    wire gates_ok = (state_nxt != hfseq_pkg::HFSEQ_COOL);
    wire [hfseq_pkg::REF_W-1:0] ref_min =
        min2(min2(bandgap_ref_i, ext_ss_level_i), iss_r);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_o         <= 2'h0;
            ea_ref_o       <= '0;
            hiccup_enter_o <= 1'b0;
        end else begin
            gate_o         <= gates_ok ? gate_req_i : 2'h0;
            ea_ref_o       <= ref_min;
            hiccup_enter_o <= enter;
        end
    end

    assign hiccup_o     = (state_r == hfseq_pkg::HFSEQ_COOL);
    assign soft_start_o = (state_r == hfseq_pkg::HFSEQ_SOFT);
endmodule
`default_nettype wire

// [hdl/hfseq_pkg.sv]
// Purpose: Shared constants and carrier types for the hiccup fault sequencer
// Assumes: 125 MHz controller clock, 8 ns period
// Notes:   Analog levels are represented as unsigned codes of REF_W bits
package hfseq_pkg;
    localparam int    CLK_PERIOD_PS = 8000;
    // Timing figures as printed
    localparam real   COOL_MS       = 5.5;
    localparam real   SS_MS         = 3.6;
    localparam real   UV_US         = 7.0;
    localparam real   HS_BLANK_NS   = 200.0;
    localparam real   LS_DELAY_NS   = 50.0;
    // Cycle counts: least times round up, never below one cycle
    localparam int    COOL_CYC      = int'($ceil(COOL_MS * 1.0E9 / CLK_PERIOD_PS));
    localparam int    SS_CYC        = int'($ceil(SS_MS * 1.0E9 / CLK_PERIOD_PS));
    localparam int    UV_CYC        = int'($ceil(UV_US * 1.0E6 / CLK_PERIOD_PS));
    localparam int    HS_BLANK_CYC  = int'($ceil(HS_BLANK_NS * 1.0E3 / CLK_PERIOD_PS));
    localparam int    LS_DELAY_CYC  = int'($ceil(LS_DELAY_NS * 1.0E3 / CLK_PERIOD_PS));
    localparam int    TMR_W         = 20;
    localparam int    SHORT_W       = 10;
    localparam int    REF_W         = 16;
    localparam logic [4:0] LS_TRIP_CNT  = 5'h0F;
    localparam logic [5:0] LS_CLEAR_CNT = 6'h20;
    localparam logic [REF_W-1:0] REF_ZERO = 16'h0000;

    typedef enum logic [1:0] {HFSEQ_RUN, HFSEQ_COOL, HFSEQ_SOFT} hfseq_state_t;

    // Raw comparator pins from the power stage
    typedef struct packed {
        logic ls_ovc;
        logic hs_ovc;
        logic output_undervoltage_fault;
    } hfseq_cmp_t;

    // Gate commands from the PWM core
    typedef struct packed {
        logic hs_on;
        logic ls_on;
    } hfseq_gate_t;
endpackage

// [sim/hfseq_stage_model.sv]
// Purpose: Behavioural power stage with its fault comparators
// Assumes: The bench asks for faults as plain levels
// Notes:   A current comparator reports only while its switch conducts
`timescale 1ns/1ps
`default_nettype none
module hfseq_stage_model (
    // Gate drives
    input  wire logic [1:0]        gate_i,
    // Fault requests
    input  wire logic              ls_flt_i,
    input  wire logic              hs_flt_i,
    input  wire logic              uv_flt_i,
    // Comparator outputs
    output var hfseq_pkg::hfseq_cmp_t cmp_o
);
    // Delay keeps the comparators off the clock edge, as real ones are
    assign #2 cmp_o = {gate_i[0] & ls_flt_i, gate_i[1] & hs_flt_i, uv_flt_i};
endmodule
`default_nettype wire

// [sim/hfseq_chk.sv]
// Purpose: Port-level properties of the hiccup fault sequencer
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Cool-down length is measured by a helper counter
`timescale 1ns/1ps
`default_nettype none
module hfseq_chk (
    // Clock and reset
    input wire logic                        mclk_i,
    input wire logic                        arst_n_i,
    // Watched ports
    input wire hfseq_pkg::hfseq_cmp_t       cmp_i,
    input wire hfseq_pkg::hfseq_gate_t      gate_req_i,
    input wire logic [hfseq_pkg::REF_W-1:0] bandgap_ref_i,
    input wire logic [hfseq_pkg::REF_W-1:0] ext_ss_level_i,
    input wire logic                        ext_ss_done_i,
    input wire logic [1:0]                  gate_o,
    input wire logic [hfseq_pkg::REF_W-1:0] ea_ref_o,
    input wire logic                        hiccup_o,
    input wire logic                        soft_start_o,
    input wire logic                        hiccup_enter_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    logic [19:0] cool_r;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) cool_r <= 20'h00000;
        else cool_r <= hiccup_o ? cool_r + 20'h00001 : 20'h00000;
    end
    sequence entry_s;
        hiccup_o ##1 (hiccup_o && ea_ref_o == hfseq_pkg::REF_ZERO);
    endsequence
    sequence quiet_s;
        (!ext_ss_done_i && !cmp_i.ls_ovc && !cmp_i.hs_ovc)[*8];
    endsequence
    a_gate_off_cool: assert property (hiccup_o |-> gate_o == 2'h0)
        else $error("gate driven during cool-down");
    a_enter_edge: assert property (hiccup_enter_o |-> hiccup_o && !$past(hiccup_o))
        else $error("entry pulse without cool-down start");
    a_enter_pulse: assert property (hiccup_enter_o |=> !hiccup_enter_o)
        else $error("entry pulse longer than one cycle");
    a_entry_clear: assert property (hiccup_enter_o |-> entry_s)
        else $error("internal soft-start not cleared on entry");
    a_cool_len: assert property ($fell(hiccup_o) |-> soft_start_o
        && cool_r >= hfseq_pkg::COOL_CYC - 1) else $error("cool-down too short");
    a_ref_lowest: assert property ($past(arst_n_i) && !$past(soft_start_o)
        && !$past(hiccup_o) |-> ea_ref_o == (($past(bandgap_ref_i) < $past(ext_ss_level_i))
        ? $past(bandgap_ref_i) : $past(ext_ss_level_i))) else $error("reference not lowest");
    a_gate_follow: assert property ($past(arst_n_i) && !hiccup_o
        |-> gate_o == $past(gate_req_i)) else $error("gate does not follow request");
    a_uv_ignored: assert property (quiet_s |=> !hiccup_enter_o)
        else $error("undervoltage trip during soft-start");
endmodule
bind hfseq_top hfseq_chk u_chk (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmp_i(cmp_i),
    .gate_req_i(gate_req_i), .bandgap_ref_i(bandgap_ref_i), .ext_ss_level_i(ext_ss_level_i),
    .ext_ss_done_i(ext_ss_done_i), .gate_o(gate_o), .ea_ref_o(ea_ref_o), .hiccup_o(hiccup_o),
    .soft_start_o(soft_start_o), .hiccup_enter_o(hiccup_enter_o));
`default_nettype wire

// [sim/hfseq_bench.sv]
// Purpose: Self-checking bench for the hiccup fault sequencer
// Assumes: Full cool-down is too long to wait out; reset ends each hiccup but the last, which ends the run
// Notes:   Inputs change on the falling edge of mclk_i
`timescale 1ns/1ps
`default_nettype none
module hfseq_bench;
    logic                   mclk_i = 1'h0;
    logic                   arst_n_i = 1'h0;
    hfseq_pkg::hfseq_cmp_t  cmp_i;
    hfseq_pkg::hfseq_gate_t gate_req_i = 2'h0;
    logic [15:0]            bg = 16'h8000;
    logic [15:0]            ext = 16'h9000;
    logic                   ss_done = 1'h1;
    logic                   ls_flt = 1'h0;
    logic                   hs_flt = 1'h0;
    logic                   uv_flt = 1'h0;
    logic [1:0]             gate_o;
    logic [15:0]            ea_ref_o;
    logic                   hiccup_o;
    logic                   ss_o;
    int                     bad_count = 0;
    int                     compares = 0;
    int                     seed = 81670;
    always #4 mclk_i = ~mclk_i;
    hfseq_top DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cmp_i(cmp_i), .gate_req_i(gate_req_i),
        .bandgap_ref_i(bg), .ext_ss_level_i(ext), .ext_ss_done_i(ss_done), .gate_o(gate_o),
        .ea_ref_o(ea_ref_o), .hiccup_o(hiccup_o), .soft_start_o(ss_o), .hiccup_enter_o());
    hfseq_stage_model stage (.gate_i(gate_o), .ls_flt_i(ls_flt), .hs_flt_i(hs_flt),
        .uv_flt_i(uv_flt), .cmp_o(cmp_i));
    task automatic wrap_up;
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_ref(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        chk_ref({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic logic [15:0] lowest(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic do_reset;
        arst_n_i = 1'h0;
        tick(16);
        arst_n_i = 1'h1;
        tick(2);
    endtask
    // One switching period: on time, then off time
    task automatic pwm(input int hs_n, input int ls_n);
        gate_req_i = 2'h2;
        tick(hs_n);
        gate_req_i = 2'h1;
        tick(ls_n);
    endtask
    task automatic ls_run(input int n, input logic f);
        ls_flt = f;
        repeat (n) pwm(30, 12);
    endtask
    // Bounded wait for cool-down to start
    task automatic wait_hic(input int lim);
        for (int i = 0; i < lim && hiccup_o !== 1'h1; i++) tick(1);
        chk_flag(hiccup_o, 1'h1);
        if (hiccup_o !== 1'h1) wrap_up();
    endtask
    initial begin
        do_reset();
        for (int i = 0; i < 24; i++) begin
            bg = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
            ext = (i == 2) ? bg : 16'($random(seed));
            ss_done = 1'($random(seed));
            tick(2);
            chk_ref(ea_ref_o, lowest(bg, ext));
        end
        ss_done = 1'h1;
        ls_run(14, 1'h1);
        chk_flag(hiccup_o, 1'h0);
        ls_run(31, 1'h0);
        ls_run(1, 1'h1);
        wait_hic(20);
        pwm(30, 12);
        chk_ref({14'h0000, gate_o}, 16'h0000);
        chk_ref(ea_ref_o, 16'h0000);
        chk_flag(ss_o, 1'h0);
        ls_flt = 1'h0;
        do_reset();
        ls_run(14, 1'h1);
        ls_run(32, 1'h0);
        ls_run(14, 1'h1);
        chk_flag(hiccup_o, 1'h0);
        ls_run(1, 1'h1);
        wait_hic(20);
        ls_flt = 1'h0;
        do_reset();
        // Soft-start still running: the high-side current limit must trip anyway
        ss_done = 1'h0;
        hs_flt = 1'h1;
        repeat (3) pwm(20, 12);
        chk_flag(hiccup_o, 1'h0);
        pwm(40, 12);
        chk_flag(hiccup_o, 1'h1);
        hs_flt = 1'h0;
        gate_req_i = 2'h0;
        do_reset();
        uv_flt = 1'h1;
        tick(2000);
        chk_flag(hiccup_o, 1'h0);
        ss_done = 1'h1;
        tick(800);
        uv_flt = 1'h0;
        tick(3);
        uv_flt = 1'h1;
        tick(860);
        chk_flag(hiccup_o, 1'h0);
        wait_hic(40);
        wrap_up();
    end
endmodule
`default_nettype wire
